// File: rtl/fdc_top.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module fdc_top
    import fdc_pkg::*;
#(
    parameter int W = 32,
    parameter int D = FDC_FIFO_DEPTH
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rstn_in,
    input  wire logic         soft_reset_in,
    input  wire logic [7:0]   reg_addr_in,
    input  wire logic [31:0]  reg_wdata_in,
    input  wire logic         reg_wr_in,
    input  wire logic         reg_rd_in,
    output logic [31:0]       reg_rdata_out,
    input  wire logic [1:0]   mp_tx_wr_in,
    input  wire logic [1:0]   bd_tx_wr_in,
    input  wire logic [W-1:0] mp_tx_data_in,
    input  wire logic [W-1:0] bd_tx_data_in,
    input  wire logic [1:0]   tx_pop_in,
    input  wire logic [W-1:0] iso_tx_hdr_in,
    input  wire logic [W-1:0] async_tx_hdr_in,
    output logic [1:0]        tx_valid_out,
    output logic [W-1:0]      iso_tx_word_out,
    output logic [W-1:0]      async_tx_word_out,
    input  wire logic [1:0]   rx_push_in,
    input  wire logic [1:0]   rx_sop_in,
    input  wire logic [W-1:0] rx_data_in,
    input  wire logic [1:0]   mp_rx_rd_in,
    input  wire logic [1:0]   bd_rx_rd_in,
    output logic [W-1:0]      mp_rx_word_out,
    output logic [W-1:0]      bd_rx_word_out,
    output logic [1:0]        bd_rx_valid_out,
    output logic [1:0]        mp_rx_valid_out
);
    logic [31:0]  ctrl;
    logic [3:0]   flush_q;
    logic [W-1:0] tx_word   [2];
    logic [W-1:0] rx_word   [2];
    logic [W-1:0] rx_hdr    [2];
    logic [1:0]   tx_valid;
    logic [1:0]   tx_empty;
    logic [1:0]   rx_empty;
    logic [1:0]   hdr_seen;
    logic [W-1:0] hdr_reg   [2];
    logic [1:0]   ch_to_bulky;
    fdc_ctrl_if ci [2] ();
    wire wr_ctrl = reg_wr_in && (reg_addr_in == FDC_CTRL_OFFSET);
    // Flush bits only strobe; they are never stored, so they read back as zero.
    wire [3:0] next_flush = wr_ctrl ? {reg_wdata_in[FDC_ASY_TFL_BIT], reg_wdata_in[FDC_ASY_RFL_BIT],
                                      reg_wdata_in[FDC_ISO_TFL_BIT], reg_wdata_in[FDC_ISO_RFL_BIT]}
                                    : 4'h0;
    wire [31:0] next_ctrl = wr_ctrl ? (reg_wdata_in & FDC_CTRL_RW_MASK) : ctrl;
    wire [31:0] status = {28'h0000000, rx_empty, tx_empty};
    wire [31:0] rd_mux = (reg_addr_in == FDC_CTRL_OFFSET)    ? ctrl :
                         (reg_addr_in == FDC_STATUS_OFFSET)  ? status :
                         (reg_addr_in == FDC_ISO_HDR_OFFSET) ? 32'(hdr_reg[FDC_ISO]) :
                         (reg_addr_in == FDC_ASY_HDR_OFFSET) ? 32'(hdr_reg[FDC_ASY]) : 32'h0000_0000;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl          <= FDC_CTRL_RESET;
            flush_q       <= 4'h0;
            reg_rdata_out <= 32'h0000_0000;
        end else if (soft_reset_in) begin
            ctrl          <= FDC_CTRL_RESET;
            flush_q       <= 4'hF;
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            ctrl          <= next_ctrl;
            flush_q       <= next_flush;
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end
    assign ci[0].insert_mode   = ctrl[FDC_ISO_HIM_BIT];
    assign ci[0].strip_mode    = ctrl[FDC_ISO_RHS_BIT];
    assign ci[0].rx_to_bulky   = ctrl[FDC_ISO_RXD_BIT];
    assign ci[0].tx_from_bulky = ctrl[FDC_ISO_TXS_BIT];
    assign ci[0].rx_flush      = flush_q[0];
    assign ci[0].tx_flush      = flush_q[1];
    assign ci[1].insert_mode   = ctrl[FDC_ASY_HIM_BIT];
    assign ci[1].strip_mode    = ctrl[FDC_ASY_RHS_BIT];
    assign ci[1].rx_to_bulky   = ctrl[FDC_ASY_RXD_BIT];
    assign ci[1].tx_from_bulky = ctrl[FDC_ASY_TXS_BIT];
    assign ci[1].rx_flush      = flush_q[2];
    assign ci[1].tx_flush      = flush_q[3];
    assign ch_to_bulky = {ctrl[FDC_ASY_RXD_BIT], ctrl[FDC_ISO_RXD_BIT]};
    wire [W-1:0] hdr_in [2];
    assign hdr_in[0] = iso_tx_hdr_in;
    assign hdr_in[1] = async_tx_hdr_in;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            fdc_channel #(.W(W), .D(D)) u_ch (
                .clk_sys_in    (clk_sys_in),
                .rstn_in       (rstn_in),
                .ctl           (ci[g]),
                .mp_tx_wr_in   (mp_tx_wr_in[g]),
                .bd_tx_wr_in   (bd_tx_wr_in[g]),
                .mp_tx_data_in (mp_tx_data_in),
                .bd_tx_data_in (bd_tx_data_in),
                .tx_pop_in     (tx_pop_in[g]),
                .tx_hdr_in     (hdr_in[g]),
                .tx_valid      (tx_valid[g]),
                .tx_word       (tx_word[g]),
                .tx_empty      (tx_empty[g]),
                .rx_push_in    (rx_push_in[g]),
                .rx_sop_in     (rx_sop_in[g]),
                .rx_data_in    (rx_data_in),
                .mp_rx_rd_in   (mp_rx_rd_in[g]),
                .bd_rx_rd_in   (bd_rx_rd_in[g]),
                .rx_word       (rx_word[g]),
                .rx_empty      (rx_empty[g]),
                .rx_hdr        (rx_hdr[g]),
                .hdr_seen      (hdr_seen[g])
            );
            always_ff @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    hdr_reg[g] <= '0;
                end else if (hdr_seen[g]) begin
                    hdr_reg[g] <= rx_hdr[g];
                end
            end
        end
    endgenerate
    // Each receive path is visible on exactly one side; the other side sees no data.
    wire [1:0]   next_bd_valid = ~rx_empty & ch_to_bulky;
    wire [1:0]   next_mp_valid = ~rx_empty & ~ch_to_bulky;
    // The shared word follows a channel that holds data, so an empty iso queue never hides async data.
    wire [W-1:0] next_bd_word  = next_bd_valid[0] ? rx_word[0] : (next_bd_valid[1] ? rx_word[1] : '0);
    wire [W-1:0] next_mp_word  = next_mp_valid[0] ? rx_word[0] : (next_mp_valid[1] ? rx_word[1] : '0);
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_valid_out      <= 2'h0;
            iso_tx_word_out   <= '0;
            async_tx_word_out <= '0;
            bd_rx_valid_out   <= 2'h0;
            mp_rx_valid_out   <= 2'h0;
            bd_rx_word_out    <= '0;
            mp_rx_word_out    <= '0;
        end else begin
            tx_valid_out      <= tx_valid;
            iso_tx_word_out   <= tx_word[0];
            async_tx_word_out <= tx_word[1];
            bd_rx_valid_out   <= next_bd_valid;
            mp_rx_valid_out   <= next_mp_valid;
            bd_rx_word_out    <= next_bd_word;
            mp_rx_word_out    <= next_mp_word;
        end
    end
endmodule // fdc_top

// File: inc/fdc_pkg.sv
// Summary of operation
// - Iso insert mode: device adds headers, packetizes
// - Iso strip: remove header, keep it
// - Iso rx dest 0: micro port reads FIFO
// - Iso rx dest 1: forward to bulky interface
// - Iso tx src 0: micro writes, bulky ignored
// - Iso tx src 1: only bulky writes accepted
// - Iso rx flush empties FIFO, self clears
// - Iso tx flush empties FIFO, self clears
// - Async insert mode: device adds headers, packetizes
// - Async strip: remove header, copy to registers
// - Async rx dest 0: micro port reads FIFO
// - Async rx dest 1: forward to bulky interface
// - Async tx src 0: micro writes, bulky ignored
// - Async tx src 1: bulky writes accepted
// - Async rx flush empties FIFO, self clears
// - Async tx flush empties FIFO, self clears
// - All control bits reset to zero
package fdc_pkg;
    localparam logic [7:0]  FDC_CTRL_OFFSET   = 8'hEC;
    localparam logic [7:0]  FDC_ISO_HDR_OFFSET = 8'hF8;
    localparam logic [7:0]  FDC_ASY_HDR_OFFSET = 8'hFC;
    localparam logic [7:0]  FDC_STATUS_OFFSET = 8'hF4;
    localparam int          FDC_ISO_HIM_BIT   = 16;
    localparam int          FDC_ISO_RHS_BIT   = 19;
    localparam int          FDC_ISO_RXD_BIT   = 20;
    localparam int          FDC_ISO_TXS_BIT   = 21;
    localparam int          FDC_ISO_RFL_BIT   = 22;
    localparam int          FDC_ISO_TFL_BIT   = 23;
    localparam int          FDC_ASY_HIM_BIT   = 24;
    localparam int          FDC_ASY_RHS_BIT   = 27;
    localparam int          FDC_ASY_RXD_BIT   = 28;
    localparam int          FDC_ASY_TXS_BIT   = 29;
    localparam int          FDC_ASY_RFL_BIT   = 30;
    localparam int          FDC_ASY_TFL_BIT   = 31;
    localparam logic [31:0] FDC_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] FDC_CTRL_RW_MASK  = 32'h3939_0000;
    localparam int          FDC_FIFO_DEPTH    = 16;
    localparam int          FDC_HDR_WORDS     = 1;
    typedef enum logic {FDC_ISO = 1'b0, FDC_ASY = 1'b1} fdc_class_t;
endpackage

// File: inc/fdc_ctrl_if.sv
`timescale 1ns/10ps
interface fdc_ctrl_if;
    logic insert_mode;
    logic strip_mode;
    logic rx_to_bulky;
    logic tx_from_bulky;
    logic rx_flush;
    logic tx_flush;
    modport ctrl (output insert_mode, strip_mode, rx_to_bulky, tx_from_bulky, rx_flush, tx_flush);
    modport path (input insert_mode, strip_mode, rx_to_bulky, tx_from_bulky, rx_flush, tx_flush);
endinterface

// File: rtl/fdc_fifo.sv
`timescale 1ns/10ps
module fdc_fifo
    import fdc_pkg::*;
#(
    parameter int W = 32,
    parameter int D = FDC_FIFO_DEPTH
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rstn_in,
    input  wire logic         flush_in,
    input  wire logic         wr_in,
    input  wire logic [W-1:0] wdata_in,
    input  wire logic         rd_in,
    output logic [W-1:0]      rdata_out,
    output logic              empty_out,
    output logic              full_out,
    output logic [$clog2(D):0] count_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    wire do_wr = wr_in && !full_out && !flush_in;
    wire do_rd = rd_in && !empty_out && !flush_in;
    assign empty_out = (cnt == '0);
    assign full_out  = (cnt == (AW+1)'(D));
    assign rdata_out = mem[rp];
    assign count_out = cnt;
    always_ff @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wp] <= wdata_in;
        end
    end
    // A flush drops everything queued and any access in the same cycle.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (flush_in) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= do_wr ? wp + 1'b1 : wp;
            rp  <= do_rd ? rp + 1'b1 : rp;
            cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // fdc_fifo

// File: rtl/fdc_channel.sv
`timescale 1ns/10ps
module fdc_channel
    import fdc_pkg::*;
#(
    parameter int W = 32,
    parameter int D = FDC_FIFO_DEPTH
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rstn_in,
    fdc_ctrl_if.path          ctl,
    input  wire logic         mp_tx_wr_in,
    input  wire logic         bd_tx_wr_in,
    input  wire logic [W-1:0] mp_tx_data_in,
    input  wire logic [W-1:0] bd_tx_data_in,
    input  wire logic         tx_pop_in,
    input  wire logic [W-1:0] tx_hdr_in,
    output logic              tx_valid,
    output logic [W-1:0]      tx_word,
    output logic              tx_empty,
    input  wire logic         rx_push_in,
    input  wire logic         rx_sop_in,
    input  wire logic [W-1:0] rx_data_in,
    input  wire logic         mp_rx_rd_in,
    input  wire logic         bd_rx_rd_in,
    output logic [W-1:0]      rx_word,
    output logic              rx_empty,
    output logic [W-1:0]      rx_hdr,
    output logic              hdr_seen
);
    logic          tx_full;
    logic          rx_full;
    logic [W-1:0]  tx_fifo_q;
    logic          hdr_sent;
    logic [$clog2(D):0] unused_tc;
    logic [$clog2(D):0] unused_rc;
    wire tx_wr   = ctl.tx_from_bulky ? bd_tx_wr_in : mp_tx_wr_in;
    wire [W-1:0] tx_wd = ctl.tx_from_bulky ? bd_tx_data_in : mp_tx_data_in;
    // Insert mode emits the generated header word before the payload taken from the FIFO.
    wire send_hdr = ctl.insert_mode && !hdr_sent && !tx_empty;
    wire tx_rd    = tx_pop_in && !send_hdr;
    assign tx_valid = !tx_empty;
    assign tx_word  = send_hdr ? tx_hdr_in : tx_fifo_q;
    wire strip_now  = ctl.strip_mode && rx_sop_in && rx_push_in;
    wire rx_wr      = rx_push_in && !strip_now;
    wire rx_rd      = ctl.rx_to_bulky ? bd_rx_rd_in : mp_rx_rd_in;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hdr_sent <= 1'b0;
            rx_hdr   <= '0;
            hdr_seen <= 1'b0;
        end else begin
            hdr_sent <= ctl.tx_flush ? 1'b0 : (tx_pop_in && send_hdr) ? 1'b1 : (tx_empty ? 1'b0 : hdr_sent);
            rx_hdr   <= strip_now ? rx_data_in : rx_hdr;
            hdr_seen <= strip_now;
        end
    end
    fdc_fifo #(.W(W), .D(D)) u_tx (
        .clk_sys_in (clk_sys_in), .rstn_in (rstn_in), .flush_in (ctl.tx_flush),
        .wr_in (tx_wr), .wdata_in (tx_wd), .rd_in (tx_rd), .rdata_out (tx_fifo_q),
        .empty_out (tx_empty), .full_out (tx_full), .count_out (unused_tc)
    );
    fdc_fifo #(.W(W), .D(D)) u_rx (
        .clk_sys_in (clk_sys_in), .rstn_in (rstn_in), .flush_in (ctl.rx_flush),
        .wr_in (rx_wr), .wdata_in (rx_data_in), .rd_in (rx_rd), .rdata_out (rx_word),
        .empty_out (rx_empty), .full_out (rx_full), .count_out (unused_rc)
    );
endmodule // fdc_channel

// File: tb/fdc_top_asserts.sv
`timescale 1ns/10ps
module fdc_top_asserts
    import fdc_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic        soft_reset_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [1:0]  mp_tx_wr_in,
    input wire logic [1:0]  bd_tx_wr_in,
    input wire logic [1:0]  tx_valid_out,
    input wire logic [1:0]  bd_rx_valid_out
);
    // Flush and unused bits are kept out of the shadow, since they must always read back as zero.
    localparam logic [31:0] RW_BITS = 32'h3939_0000;
    logic [31:0] shadow;
    wire         ctrl_wr = reg_wr_in && (reg_addr_in == FDC_CTRL_OFFSET);
    wire         ctrl_rd = reg_rd_in && (reg_addr_in == FDC_CTRL_OFFSET);
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) shadow <= 32'h0000_0000;
        else if (soft_reset_in) shadow <= 32'h0000_0000;
        else if (ctrl_wr) shadow <= reg_wdata_in & RW_BITS;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence s_flush(int b); ctrl_wr && reg_wdata_in[b]; endsequence
    sequence s_quiet(int c); (!mp_tx_wr_in[c] && !bd_tx_wr_in[c]) [*4]; endsequence
    property p_tflush(int b, int c); s_flush(b) ##1 s_quiet(c) |-> !tx_valid_out[c]; endproperty
    AST_CTRL_READBACK: assert property (ctrl_rd |=> reg_rdata_out == $past(shadow))
        else $error("control readback differs from written value");
    AST_FLUSH_READS_ZERO: assert property (ctrl_rd |=> reg_rdata_out[23:22] == 2'h0 && reg_rdata_out[31:30] == 2'h0)
        else $error("flush bit read back as one");
    AST_SOFT_RESET_CLEARS: assert property (soft_reset_in ##1 ctrl_rd |=> reg_rdata_out == 32'h0000_0000)
        else $error("control not cleared by soft reset");
    AST_ISO_RX_STAYS_MP: assert property (!shadow[FDC_ISO_RXD_BIT] && !$past(shadow[FDC_ISO_RXD_BIT]) |-> !bd_rx_valid_out[0])
        else $error("iso rx word sent to bulky side");
    AST_ASY_RX_STAYS_MP: assert property (!shadow[FDC_ASY_RXD_BIT] && !$past(shadow[FDC_ASY_RXD_BIT]) |-> !bd_rx_valid_out[1])
        else $error("async rx word sent to bulky side");
    AST_ISO_TX_FLUSH: assert property (p_tflush(FDC_ISO_TFL_BIT, 0))
        else $error("iso tx fifo not empty after flush");
    AST_ASY_TX_FLUSH: assert property (p_tflush(FDC_ASY_TFL_BIT, 1))
        else $error("async tx fifo not empty after flush");
    AST_ISO_SRC_IGNORES_BD: assert property (s_flush(FDC_ISO_TFL_BIT) ##1
        (!mp_tx_wr_in[0] && !shadow[FDC_ISO_TXS_BIT]) [*4] |-> !tx_valid_out[0])
        else $error("bulky write reached iso tx fifo");
endmodule // fdc_top_asserts
bind fdc_top fdc_top_asserts fdc_top_asserts_inst (.clk_sys_in, .rstn_in, .soft_reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mp_tx_wr_in, .bd_tx_wr_in, .tx_valid_out,
    .bd_rx_valid_out);

// File: tb/fdc_bulky_app.sv
`timescale 1ns/10ps
module fdc_bulky_app (
    input  wire logic        clk_sys_in,
    output logic [1:0]       bd_tx_wr_out,
    output logic [31:0]      bd_tx_data_out,
    output logic [1:0]       bd_rx_rd_out,
    input  wire logic [1:0]  bd_rx_valid_in,
    input  wire logic [31:0] bd_rx_word_in
);
    initial begin
        bd_tx_wr_out = 2'h0;
        bd_tx_data_out = 32'h0000_0000;
        bd_rx_rd_out = 2'h0;
    end
    // The caller hands raw payload or whole packets as the insert mode asks; no framing is added here.
    task automatic send(input int c, input logic [31:0] d, input int gap);
        repeat (gap) @(posedge clk_sys_in);
        @(posedge clk_sys_in);
        bd_tx_wr_out[c] <= 1'b1;
        bd_tx_data_out <= d;
        @(posedge clk_sys_in);
        bd_tx_wr_out <= 2'h0;
        // Released data shows the inverse, so a late capture can never match by chance.
        bd_tx_data_out <= ~d;
    endtask
    task automatic take(input int c, output logic [31:0] d, output logic ok);
        @(posedge clk_sys_in);
        bd_rx_rd_out[c] <= 1'b1;
        @(posedge clk_sys_in);
        bd_rx_rd_out <= 2'h0;
        ok = 1'b0;
        repeat (5) if (ok !== 1'b1) begin
            #1 ok = bd_rx_valid_in[c];
            d = bd_rx_word_in;
            if (ok !== 1'b1) @(posedge clk_sys_in);
        end
    endtask
endmodule // fdc_bulky_app

// File: tb/fdc_top_test.sv
`timescale 1ns/10ps
module fdc_top_test
    import fdc_pkg::*;
;
    localparam logic [7:0] CTL = FDC_CTRL_OFFSET;
    localparam logic [7:0] STS = FDC_STATUS_OFFSET;
    logic        clk = 1'b0, rstn = 1'b0, srst = 1'b0, wr = 1'b0, rd = 1'b0, ok;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0, mtd = 32'h0, rxd = 32'h0, r, rdat, itw, atw, mrw, brw, btd;
    logic [31:0] ihdr = 32'hA5A5_0001, ahdr = 32'h5A5A_0002;
    logic [1:0]  mtw = 2'h0, pop = 2'h0, rpush = 2'h0, rsop = 2'h0, mrd = 2'h0, btw, brd, txv, brv, mrv;
    int          miscompares = 0, check_count = 0, cyc = 0;
    fdc_top #(.W(32)) fdc_top_inst (
        .clk_sys_in(clk), .rstn_in(rstn), .soft_reset_in(srst), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .mp_tx_wr_in(mtw), .bd_tx_wr_in(btw),
        .mp_tx_data_in(mtd), .bd_tx_data_in(btd), .tx_pop_in(pop), .iso_tx_hdr_in(ihdr),
        .async_tx_hdr_in(ahdr), .tx_valid_out(txv), .iso_tx_word_out(itw), .async_tx_word_out(atw),
        .rx_push_in(rpush), .rx_sop_in(rsop), .rx_data_in(rxd), .mp_rx_rd_in(mrd), .bd_rx_rd_in(brd),
        .mp_rx_word_out(mrw), .bd_rx_word_out(brw), .bd_rx_valid_out(brv), .mp_rx_valid_out(mrv));
    fdc_bulky_app fdc_bulky_app_inst (.clk_sys_in(clk), .bd_tx_wr_out(btw), .bd_tx_data_out(btd),
        .bd_rx_rd_out(brd), .bd_rx_valid_in(brv), .bd_rx_word_in(brw));
    initial forever #10 clk = ~clk;
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t ns: flag %b, expected %b", $time, g, e);
        end
    endtask
    function automatic logic [31:0] b(input int n);
        return 32'h0000_0001 << n;
    endfunction
    function automatic logic [31:0] tw(input int c);
        return c ? atw : itw;
    endfunction
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic pls(input int k, input int c, input logic [31:0] d);
        @(posedge clk);
        mtd <= d;
        rxd <= d;
        case (k)
            0: mtw[c] <= 1'b1;
            1: pop[c] <= 1'b1;
            2: mrd[c] <= 1'b1;
            3: rpush[c] <= 1'b1;
            default: begin
                rpush[c] <= 1'b1;
                rsop[c] <= 1'b1;
            end
        endcase
        @(posedge clk);
        {mtw, pop, mrd, rpush, rsop} <= 10'h000;
    endtask
    task automatic waitv(input int c, input logic m);
        logic v;
        v = 1'b0;
        repeat (5) if (v !== 1'b1) begin
            #1 v = m ? mrv[c] : txv[c];
            if (v !== 1'b1) @(posedge clk);
        end
    endtask
    task automatic t_regs();
        rdr(CTL, r);
        chk32(r, 32'h0000_0000);
        rdr(STS, r);
        chk32(r, 32'h0000_000F);
        wrr(CTL, 32'hFFFF_FFFF);
        rdr(CTL, r);
        chk32(r, 32'h3939_0000);
        rdr(8'h10, r);
        chk32(r, 32'h0000_0000);
        wrr(CTL, 32'h0000_0000);
    endtask
    task automatic t_tx(input int c);
        fdc_bulky_app_inst.send(c, 32'hB0B0_0000, 0);
        rdr(STS, r);
        chk1(r[c], 1'b1);
        pls(0, c, 32'hC0C0_0001);
        rdr(STS, r);
        chk1(r[c], 1'b0);
        wrr(CTL, b(FDC_ISO_TFL_BIT + 8 * c));
        rdr(CTL, r);
        chk32(r, 32'h0000_0000);
        rdr(STS, r);
        chk1(r[c], 1'b1);
        wrr(CTL, b(FDC_ISO_TXS_BIT + 8 * c));
        pls(0, c, 32'hC0C0_0002);
        rdr(STS, r);
        chk1(r[c], 1'b1);
        fdc_bulky_app_inst.send(c, 32'hB0B0_0003, 3);
        rdr(STS, r);
        chk1(r[c], 1'b0);
        wrr(CTL, b(FDC_ISO_TFL_BIT + 8 * c));
    endtask
    task automatic t_ins(input int c);
        wrr(CTL, b(FDC_ISO_HIM_BIT + 8 * c) | b(FDC_ISO_TXS_BIT + 8 * c));
        fdc_bulky_app_inst.send(c, 32'hD0D0_0001, 0);
        @(posedge clk);
        waitv(c, 1'b0);
        chk32(tw(c), c ? ahdr : ihdr);
        pls(1, c, 32'h0000_0000);
        @(posedge clk);
        waitv(c, 1'b0);
        chk32(tw(c), 32'hD0D0_0001);
        pls(1, c, 32'h0000_0000);
        wrr(CTL, 32'h0000_0000);
        pls(0, c, 32'hE0E0_0002);
        @(posedge clk);
        waitv(c, 1'b0);
        chk32(tw(c), 32'hE0E0_0002);
        pls(1, c, 32'h0000_0000);
    endtask
    task automatic t_rx(input int c);
        wrr(CTL, b(FDC_ISO_RHS_BIT + 8 * c));
        pls(4, c, 32'h4EAD_0001);
        pls(3, c, 32'h9A70_0002);
        pls(2, c, 32'h0000_0000);
        waitv(c, 1'b1);
        chk32(mrw, 32'h9A70_0002);
        rdr(c ? FDC_ASY_HDR_OFFSET : FDC_ISO_HDR_OFFSET, r);
        chk32(r, 32'h4EAD_0001);
        wrr(CTL, b(FDC_ISO_RXD_BIT + 8 * c));
        pls(3, c, 32'h9A70_0003);
        fdc_bulky_app_inst.take(c, r, ok);
        chk1(ok, 1'b1);
        chk32(r, 32'h9A70_0003);
        pls(3, c, 32'h9A70_0004);
        wrr(CTL, b(FDC_ISO_RFL_BIT + 8 * c));
        rdr(STS, r);
        chk1(r[2 + c], 1'b1);
    endtask
    task automatic t_soft();
        wrr(CTL, 32'h3939_0000);
        pls(3, 0, 32'h1234_5678);
        @(posedge clk);
        srst <= 1'b1;
        // The read follows the soft reset with no gap, so the checker sees it right behind the pulse.
        @(posedge clk);
        srst <= 1'b0;
        addr <= CTL;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdat;
        chk32(r, 32'h0000_0000);
        rdr(STS, r);
        chk32(r, 32'h0000_000F);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        for (int c = 0; c < 2; c++) begin
            t_tx(c);
            t_ins(c);
            t_rx(c);
        end
        t_soft();
        report_and_stop();
    end
endmodule // fdc_top_test
